/* core/sfh_defs.vh */
/*
 Constants for the host-side unlock and lockdown sequencer of a serial
 flash controller. Assumes the flash controller registers sit behind a
 plain word-addressed register port with read data one cycle later.
*/
// Notes on behaviour
// - Flash ignores all but read-status while writing
// - Unlock writes zero byte via atomic cycle
// - Prefix register holds write-enable opcode
// - Menu holds write-status, type no-address write
// - First data word cleared before launch
// - Pointers select write-status and write-enable prefix
// - Set data and atomic bits, then go
// - Software sets lockdown at offset 04h
// - Program capabilities when table invalid (code writes them when the component lock bit 23 reads clear)
// - Single component uses component 0 register
`ifndef SFH_DEFS_VH
`define SFH_DEFS_VH

// -----------------------------------------------------------------
// Flash controller register offsets
// -----------------------------------------------------------------
`define SFH_DEV_LOCKDOWN     8'h04
`define SFH_DEV_OVERRIDE     8'hc4
`define SFH_DEV_SW_STATUS    8'h90
`define SFH_DEV_SW_CONTROL   8'h91
`define SFH_DEV_DATA0        8'h10
`define SFH_DEV_PREFIX       8'ha4
`define SFH_DEV_OPTYPE       8'ha6
`define SFH_DEV_OPMENU       8'ha8
`define SFH_DEV_COMP0_CAP    8'hc8

// -----------------------------------------------------------------
// Flash controller fields and opcodes
// -----------------------------------------------------------------
`define SFH_OP_WRITE_ENABLE  8'h06
`define SFH_OP_WRITE_STATUS  8'h01
`define SFH_OPTYPE_WR_NOADDR 2'h1
`define SFH_ZERO_WORD        32'h00000000
`define SFH_OVERRIDE_BIT     13
`define SFH_LOCKDOWN_BIT     15
`define SFH_COMP_LOCK_BIT    23
`define SFH_TABLE_VALID_BIT  31
`define SFH_SWS_BUSY_BIT     0
`define SFH_SWS_ERROR_BIT    3
`define SFH_SWC_GO_BIT       1
`define SFH_SWC_ATOMIC_BIT   2
`define SFH_SWC_PREFIX_BIT   3
`define SFH_SWC_COP_LSB      4
`define SFH_SWC_DBC_LSB      8
`define SFH_SWC_DATA_BIT     14

// -----------------------------------------------------------------
// Own software registers
// -----------------------------------------------------------------
`define SFH_REG_COMMAND      4'h0
`define SFH_REG_CONFIG       4'h4
`define SFH_REG_STATUS       4'h8
`define SFH_REG_LASTREAD     4'hc
`define SFH_CMD_UNLOCK_BIT   0
`define SFH_CMD_LOCK_BIT     1
`define SFH_CMD_OVERRIDE_BIT 2
`define SFH_CFG_RESET        32'h00000000

`endif

/* core/sfh_unlock_host.v */
/*
 Host sequencer: software orders an atomic status-register unlock, a
 configuration lockdown, or an override-strap read; the block then drives
 the flash controller registers step by step.
 Assumes the controller answers reads one cycle after the read strobe and
 never stalls writes.
*/
// Implementation choices: the plain strobed port and the address map.
`include "sfh_defs.vh"

module sfh_unlock_host (
	input  wire        clk_sys,
	input  wire        rstn,
	input  wire [3:0]  swAddr,
	input  wire [31:0] swWdata,
	input  wire        swWr,
	input  wire        swRd,
	output reg  [31:0] swRdata,
	output reg  [7:0]  devAddr,
	output reg  [31:0] devWdata,
	output reg         devWr,
	output reg         devRd,
	input  wire [31:0] devRdata
);

	// -----------------------------------------------------------------
	// Steps and states
	// -----------------------------------------------------------------
	localparam [3:0] ST_PREFIX  = 4'h0;
	localparam [3:0] ST_OPTYPE  = 4'h1;
	localparam [3:0] ST_OPMENU  = 4'h2;
	localparam [3:0] ST_DATA0   = 4'h3;
	localparam [3:0] ST_LAUNCH  = 4'h4;
	localparam [3:0] ST_POLL    = 4'h5;
	localparam [3:0] ST_CAPRD   = 4'h6;
	localparam [3:0] ST_CAPWR   = 4'h7;
	localparam [3:0] ST_LOCKDN  = 4'h8;
	localparam [3:0] ST_OVRD    = 4'h9;

	localparam [1:0] FS_IDLE  = 2'h0;
	localparam [1:0] FS_ISSUE = 2'h1;
	localparam [1:0] FS_WAIT  = 2'h2;
	localparam [1:0] FS_GAP   = 2'h3;

	reg [1:0]  fsmQ;
	reg [3:0]  stepQ;
	reg [31:0] cfgQ;
	reg        busyQ;
	reg        doneQ;
	reg        errorQ;
	reg        overrideQ;
	reg        tableValidQ;
	reg [31:0] lastReadQ;
	reg        startUnlock;
	reg        startLock;
	reg        startOverride;

	// -----------------------------------------------------------------
	// Step decode
	// -----------------------------------------------------------------
	function [7:0] stepAddr;
		input [3:0] step;
		begin
			case (step)
				ST_PREFIX: stepAddr = `SFH_DEV_PREFIX;
				ST_OPTYPE: stepAddr = `SFH_DEV_OPTYPE;
				ST_OPMENU: stepAddr = `SFH_DEV_OPMENU;
				ST_DATA0:  stepAddr = `SFH_DEV_DATA0;
				ST_LAUNCH: stepAddr = `SFH_DEV_SW_CONTROL;
				ST_POLL:   stepAddr = `SFH_DEV_SW_STATUS;
				ST_CAPRD:  stepAddr = `SFH_DEV_COMP0_CAP;
				ST_CAPWR:  stepAddr = `SFH_DEV_COMP0_CAP;
				ST_LOCKDN: stepAddr = `SFH_DEV_LOCKDOWN;
				ST_OVRD:   stepAddr = `SFH_DEV_OVERRIDE;
				default:   stepAddr = 8'h00;
			endcase
		end
	endfunction

	function stepIsRead;
		input [3:0] step;
		begin
			stepIsRead = (step == ST_POLL) || (step == ST_CAPRD) || (step == ST_OVRD);
		end
	endfunction

	wire [2:0] menuIndex = cfgQ[18:16];
	wire       prefixSel = cfgQ[20];

	reg [31:0] stepWord;
	always @* begin
		stepWord = 32'h00000000;
		case (stepQ)
			ST_PREFIX: begin
				stepWord[8*prefixSel +: 8] = `SFH_OP_WRITE_ENABLE;
			end
			ST_OPTYPE: begin
				stepWord[2*menuIndex +: 2] = `SFH_OPTYPE_WR_NOADDR;
			end
			ST_OPMENU: begin
				stepWord[8*menuIndex[1:0] +: 8] = `SFH_OP_WRITE_STATUS;
			end
			ST_DATA0: begin
				stepWord = `SFH_ZERO_WORD;
			end
			ST_LAUNCH: begin
				stepWord[`SFH_SWC_COP_LSB +: 3] = menuIndex;
				stepWord[`SFH_SWC_PREFIX_BIT] = prefixSel;
				stepWord[`SFH_SWC_DBC_LSB +: 6] = 6'h00;
				stepWord[`SFH_SWC_DATA_BIT] = 1'b1;
				stepWord[`SFH_SWC_ATOMIC_BIT] = 1'b1;
				stepWord[`SFH_SWC_GO_BIT] = 1'b1;
			end
			ST_CAPWR: begin
				stepWord[15:0] = cfgQ[15:0];
				stepWord[`SFH_COMP_LOCK_BIT] = 1'b1;
			end
			ST_LOCKDN: begin
				stepWord[`SFH_LOCKDOWN_BIT] = 1'b1;
			end
			default: begin
				stepWord = 32'h00000000;
			end
		endcase
	end

	// -----------------------------------------------------------------
	// Software port
	// -----------------------------------------------------------------
	always @* begin
		startUnlock = 1'b0;
		startLock = 1'b0;
		startOverride = 1'b0;
		if (swWr && swAddr == `SFH_REG_COMMAND && !busyQ) begin
			startUnlock = swWdata[`SFH_CMD_UNLOCK_BIT];
			startLock = !swWdata[`SFH_CMD_UNLOCK_BIT] && swWdata[`SFH_CMD_LOCK_BIT];
			startOverride = !swWdata[`SFH_CMD_UNLOCK_BIT] && !swWdata[`SFH_CMD_LOCK_BIT]
				&& swWdata[`SFH_CMD_OVERRIDE_BIT];
		end
	end

	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cfgQ <= `SFH_CFG_RESET;
			swRdata <= 32'h00000000;
		end else begin
			if (swWr && swAddr == `SFH_REG_CONFIG && !busyQ) begin
				cfgQ <= swWdata;
			end
			if (swRd) begin
				case (swAddr)
					`SFH_REG_CONFIG:   swRdata <= cfgQ;
					`SFH_REG_STATUS:   swRdata <= {27'h0, tableValidQ, overrideQ, errorQ, doneQ, busyQ};
					`SFH_REG_LASTREAD: swRdata <= lastReadQ;
					default:           swRdata <= 32'h00000000;
				endcase
			end else begin
				swRdata <= 32'h00000000;
			end
		end
	end

	// -----------------------------------------------------------------
	// Sequencer
	// -----------------------------------------------------------------
	wire doneClear = swWr && swAddr == `SFH_REG_STATUS && swWdata[1];

	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			fsmQ <= FS_IDLE;
			stepQ <= ST_PREFIX;
			busyQ <= 1'b0;
			doneQ <= 1'b0;
			errorQ <= 1'b0;
			overrideQ <= 1'b0;
			tableValidQ <= 1'b0;
			lastReadQ <= 32'h00000000;
			devAddr <= 8'h00;
			devWdata <= 32'h00000000;
			devWr <= 1'b0;
			devRd <= 1'b0;
		end else begin
			devWr <= 1'b0;
			devRd <= 1'b0;
			if (doneClear) begin
				doneQ <= 1'b0;
			end
			case (fsmQ)
				FS_IDLE: begin
					if (startUnlock || startLock || startOverride) begin
						busyQ <= 1'b1;
						errorQ <= 1'b0;
						fsmQ <= FS_ISSUE;
						stepQ <= startUnlock ? ST_PREFIX : (startLock ? ST_CAPRD : ST_OVRD);
					end
				end
				FS_ISSUE: begin
					devAddr <= stepAddr(stepQ);
					devWdata <= stepWord;
					if (stepIsRead(stepQ)) begin
						devRd <= 1'b1;
						fsmQ <= FS_GAP;
					end else begin
						devWr <= 1'b1;
						if (stepQ == ST_LAUNCH) begin
							stepQ <= ST_POLL;
						end else if (stepQ == ST_LOCKDN) begin
							fsmQ <= FS_IDLE;
							busyQ <= 1'b0;
							doneQ <= 1'b1;
						end else begin
							stepQ <= stepQ + 4'h1;
						end
					end
				end
				FS_GAP: begin
					fsmQ <= FS_WAIT;
				end
				FS_WAIT: begin
					lastReadQ <= devRdata;
					fsmQ <= FS_ISSUE;
					case (stepQ)
						ST_POLL: begin
							if (devRdata[`SFH_SWS_ERROR_BIT]) begin
								errorQ <= 1'b1;
								fsmQ <= FS_IDLE;
								busyQ <= 1'b0;
								doneQ <= 1'b1;
							end else if (!devRdata[`SFH_SWS_BUSY_BIT]) begin
								fsmQ <= FS_IDLE;
								busyQ <= 1'b0;
								doneQ <= 1'b1;
							end
						end
						ST_CAPRD: begin
							tableValidQ <= devRdata[`SFH_TABLE_VALID_BIT];
							if (devRdata[`SFH_COMP_LOCK_BIT]) begin
								stepQ <= ST_LOCKDN;
							end else begin
								stepQ <= ST_CAPWR;
							end
						end
						ST_OVRD: begin
							overrideQ <= !devRdata[`SFH_OVERRIDE_BIT];
							fsmQ <= FS_IDLE;
							busyQ <= 1'b0;
							doneQ <= 1'b1;
						end
						default: begin
							fsmQ <= FS_IDLE;
							busyQ <= 1'b0;
						end
					endcase
				end
				default: begin
					fsmQ <= FS_IDLE;
					busyQ <= 1'b0;
				end
			endcase
		end
	end

endmodule

/* testbench/sfh_flash_model.sv */
/*
 Flash controller register model.
 Assumes one-cycle strobes, read data the cycle after.
*/
module sfh_flash_model (
	input  wire        clk_sys,
	input  wire        rstn,
	input  wire [7:0]  devAddr,
	input  wire [31:0] devWdata,
	input  wire        devWr,
	input  wire        devRd,
	output wire [31:0] devRdata,
	input  wire [2:0]  polls,
	input  wire        errIn,
	input  wire        ovrN,
	input  wire        tblOk
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] capQ;
	logic [31:0] rdQ;
	logic [2:0]  busyQ;
	logic        vQ;
	// Stale read data shown inverted
	assign devRdata = vQ ? rdQ : ~rdQ;
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			capQ <= 32'h0;
			rdQ <= 32'h0;
			busyQ <= 3'h0;
			vQ <= 1'b0;
		end else begin
			vQ <= devRd;
			if (devRd && devAddr == 8'h90) begin
				rdQ <= {28'h0, errIn, 2'h0, busyQ != 3'h0};
				if (busyQ != 3'h0)
					busyQ <= busyQ - 3'h1;
			end else if (devRd)
				rdQ <= devAddr == 8'hc4 ? {18'h0, ovrN, 13'h0} : {tblOk, capQ[30:0]};
			else if (devWr && busyQ == 3'h0) begin
				if (devAddr == 8'h91 && devWdata[1])
					busyQ <= polls;
				if (devAddr == 8'hc8 && !capQ[23])
					capQ <= {8'h0, devWdata[23], 7'h0, devWdata[15:0]};
			end
		end
	end
endmodule

/* testbench/sfh_unlock_host_asserts.sv */
/*
 Checker for the unlock sequencer device port.
 Assumes the design drives one-cycle strobes.
*/
module sfh_host_checker (
	input wire logic        clk_sys,
	input wire logic        rstn,
	input wire logic [7:0]  devAddr,
	input wire logic [31:0] devWdata,
	input wire logic        devWr,
	input wire logic        devRd,
	input wire logic [31:0] devRdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic pendQ;
	logic atomQ;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);
	// --------
	// Atomic window tracking
	// --------
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pendQ <= 1'b0;
			atomQ <= 1'b0;
		end else begin
			pendQ <= devRd && devAddr == 8'h90;
			if (devWr && devAddr == 8'h91)
				atomQ <= 1'b1;
			else if (pendQ && (!devRdata[0] || devRdata[3]))
				atomQ <= 1'b0;
		end
	end
	chk_seq_order: assert property (
		devWr && devAddr == 8'ha4 |=> (devWr && devAddr == 8'ha6) ##1 (devWr && devAddr == 8'ha8)
		##1 (devWr && devAddr == 8'h10) ##1 (devWr && devAddr == 8'h91)) else $error("unlock order broken");
	chk_go_bits: assert property (
		devWr && devAddr == 8'h91 |-> devWdata[2:1] == 2'h3 && devWdata[14:8] == 7'h40)
		else $error("go word wrong");
	chk_data_zero: assert property (
		devWr && devAddr == 8'h10 |-> devWdata == 32'h0) else $error("data word not zero");
	chk_prefix_op: assert property (
		devWr && devAddr == 8'ha4 |-> devWdata[7:0] == 8'h06 || devWdata[15:8] == 8'h06)
		else $error("prefix opcode missing");
	chk_menu_op: assert property (
		devWr && devAddr == 8'ha8 |-> devWdata[7:0] == 8'h01 || devWdata[15:8] == 8'h01
		|| devWdata[23:16] == 8'h01 || devWdata[31:24] == 8'h01) else $error("menu opcode missing");
	chk_first_poll: assert property (
		devWr && devAddr == 8'h91 |=> devRd && devAddr == 8'h90) else $error("no status poll");
	chk_atomic_quiet: assert property (
		atomQ |-> !devWr && (!devRd || devAddr == 8'h90)) else $error("command inside atomic cycle");
	chk_repoll: assert property (
		atomQ && pendQ && devRdata[0] && !devRdata[3] |-> ##2 (devRd && devAddr == 8'h90))
		else $error("poll stopped while busy");
	chk_lock_bit: assert property (
		devWr && devAddr == 8'hc8 |-> devWdata[23]) else $error("lock bit not set");
	chk_lockdown_bit: assert property (
		devWr && devAddr == 8'h04 |-> devWdata[15]) else $error("lockdown bit not set");
	cover property (devWr && devAddr == 8'h91);
	cover property (atomQ && pendQ && devRdata[0]);
	cover property (devWr && devAddr == 8'h04);
endmodule

bind sfh_unlock_host sfh_host_checker chk (.clk_sys(clk_sys), .rstn(rstn), .devAddr(devAddr),
	.devWdata(devWdata), .devWr(devWr), .devRd(devRd), .devRdata(devRdata));

/* testbench/testbench.sv */
/*
 Self-checking bench for the unlock sequencer.
 Assumes the model and checker files are compiled first.
*/
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_sys, rstn, swWr, swRd, devWr, devRd, errIn, ovrN, tblOk;
	logic [3:0]  swAddr;
	logic [7:0]  devAddr;
	logic [2:0]  polls;
	logic [31:0] swWdata, swRdata, devWdata, devRdata, d, cfg, exp;
	integer      seed, fails, checksDone, i;
	sfh_unlock_host dut (.clk_sys(clk_sys), .rstn(rstn), .swAddr(swAddr), .swWdata(swWdata),
		.swWr(swWr), .swRd(swRd), .swRdata(swRdata), .devAddr(devAddr), .devWdata(devWdata),
		.devWr(devWr), .devRd(devRd), .devRdata(devRdata));
	sfh_flash_model dev (.clk_sys(clk_sys), .rstn(rstn), .devAddr(devAddr), .devWdata(devWdata),
		.devWr(devWr), .devRd(devRd), .devRdata(devRdata), .polls(polls), .errIn(errIn),
		.ovrN(ovrN), .tblOk(tblOk));
	// --------
	// Bus tasks
	// --------
	task automatic wrReg(input [3:0] a, input [31:0] v);
		@(posedge clk_sys);
		swAddr <= a;
		swWdata <= v;
		swWr <= 1'b1;
		@(posedge clk_sys);
		swWr <= 1'b0;
	endtask
	task automatic rdReg(input [3:0] a, output [31:0] v);
		@(posedge clk_sys);
		swAddr <= a;
		swRd <= 1'b1;
		@(posedge clk_sys);
		swRd <= 1'b0;
		#1 v = swRdata;
	endtask
	task automatic check(input [31:0] e, input [31:0] g, input string n);
		checksDone++;
		if (g !== e) begin
			$display("wrong value %s exp %h got %h", n, e, g);
			fails++;
		end
	endtask
	task automatic complete_run;
		$display("checks %0d fails %0d", checksDone, fails);
		if (fails == 0 && checksDone > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic waitDone(output [31:0] s);
		for (int k = 0; k < 200; k++) begin
			rdReg(4'h8, s);
			if (s[1])
				return;
		end
		fails++;
		complete_run();
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	// --------
	// Scenarios
	// --------
	initial begin
		seed = 69;
		fails = 0;
		checksDone = 0;
		{rstn, swWr, swRd, swAddr, swWdata, polls, errIn, tblOk} = '0;
		ovrN = 1'b1;
		repeat (20) @(posedge clk_sys);
		rstn <= 1'b1;
		rdReg(4'h8, d);
		check(32'h0, d, "status");
		rdReg(4'h2, d);
		check(32'h0, d, "unmapped");
		$display("test reset done");
		for (i = 0; i < 4; i++) begin
			polls <= i == 3 ? 3'h0 : 3'($random(seed));
			errIn <= i == 3;
			cfg = $random(seed) & 32'h001f_ffff;
			wrReg(4'h4, cfg);
			wrReg(4'h0, 32'h1);
			waitDone(d);
			check({29'h0, i == 3, 2'h2}, {29'h0, d[2:0]}, "unlock");
			wrReg(4'h8, 32'h2);
		end
		errIn <= 1'b0;
		$display("test unlock done");
		for (i = 0; i < 2; i++) begin
			ovrN <= i[0];
			wrReg(4'h0, 32'h4);
			waitDone(d);
			check({31'h0, ~i[0]}, {31'h0, d[3]}, "override");
			wrReg(4'h8, 32'h2);
		end
		$display("test override done");
		tblOk <= 1'b1;
		for (i = 0; i < 2; i++) begin
			cfg = $random(seed) & 32'hffff;
			if (i == 0)
				exp = {16'h0080, cfg[15:0]};
			wrReg(4'h4, cfg);
			wrReg(4'h0, 32'h2);
			waitDone(d);
			check(32'h10, d & 32'h10, "valid");
			wrReg(4'h8, 32'h2);
		end
		rdReg(4'hc, d);
		check(exp | 32'h8000_0000, d, "capability");
		$display("test lock done");
		complete_run();
	end
endmodule
